// ===== logic/btcc_exec.sv
/*
 Execution stage for bit-test-and-skip, test-then-set, long indirect call and compare.
 Assumes the decoder holds an operation until READY and supplies operands with it.
*/
// How it works
// RL1 - Skip-if-clear tests a chosen bit; skips next when zero; no flags changed.
// RL2 - Skip-if-set tests a chosen bit; skips next when one; no flags changed.
// RL3 - Test-then-set copies chosen bit into carry, then sets that bit; one cycle.
// RL4 - Test-then-set loads zero flag from chosen bit test, then sets it.
// RL5 - Long indirect call jumps to register address, saves return, four cycles.
// RL6 - Compare with eight bit literal updates C, DC, N, OV, Z; one cycle.
// RL7 - Register compare base minus source updates five flags, result discarded.
// RL8 - Compare-against-zero on file register updates five flags, register untouched.
// RL9 - Compare-against-zero on working register updates five flags, operand untouched.
// RL10 - Skip costs two cycles over one word, three over two words.
`timescale 1ns/1ps
module btcc_exec
    import btcc_pkg::*;
(
    input  wire logic                CORE_CLK,
    input  wire logic                NRST,
    input  wire logic                ISSUE,
    input  wire btcc_pkg::btcc_op_t  OPCODE,
    input  wire logic [15:0]         OPERAND_A,
    input  wire logic [15:0]         OPERAND_B,
    input  wire logic [3:0]          BIT_SEL,
    input  wire logic [7:0]          LITERAL,
    input  wire logic                NEXT_TWO_WORD,
    input  wire logic [23:0]         RETURN_PC,
    output logic                     READY,
    output logic [4:0]               STATUS_FLAGS,
    output logic                     STACK_FRAME_ACTIVE,
    output logic                     SKIP_NEXT,
    output logic                     WB_VALID,
    output logic [15:0]              WB_DATA,
    output logic                     BRANCH_VALID,
    output logic [23:0]              BRANCH_TARGET,
    output logic                     PUSH_VALID,
    output logic [23:0]              PUSH_DATA
);
    import btcc_pkg::*;

    typedef enum logic [2:0]
    {
        ST_IDLE = 3'b001,
        ST_BUSY = 3'b010,
        ST_DONE = 3'b100
    } btcc_state_t;

    btcc_state_t       state;
    logic [2:0]        busy_cnt;
    logic              take;
    logic              bit_val;
    logic [2:0]        next_cycles;
    btcc_alu_if        alu ();

    function automatic logic pick_bit(input logic [15:0] w, input logic [3:0] idx);
        pick_bit = w[idx];
    endfunction

    function automatic logic is_cmp(input btcc_op_t op);
        is_cmp = (op == BTCC_OP_CMP_LIT) || (op == BTCC_OP_CMP_REG)
              || (op == BTCC_OP_CMP_ZERO);
    endfunction

    btcc_compare u_compare
    (
        .bus (alu.alu)
    );

    assign take    = ISSUE && READY;
    assign bit_val = pick_bit(OPERAND_A, BIT_SEL);

    always_comb
    begin
        alu.minuend    = OPERAND_A;
        alu.subtrahend = OPERAND_B; // see RL7
        case (OPCODE)
            BTCC_OP_CMP_LIT:  alu.subtrahend = {8'h00, LITERAL}; // see RL6
            BTCC_OP_CMP_ZERO: alu.subtrahend = ZERO_WORD;        // see RL8 see RL9
            default:          alu.subtrahend = OPERAND_B;
        endcase
    end

    // Total occupancy of the issued operation, in cycles
    always_comb
    begin
        next_cycles = CYC_ONE;
        case (OPCODE)
            BTCC_OP_SKIP_CLR:
                if (!bit_val)
                    next_cycles = NEXT_TWO_WORD ? CYC_SKIP2 : CYC_SKIP1; // see RL1 see RL10
            BTCC_OP_SKIP_SET:
                if (bit_val)
                    next_cycles = NEXT_TWO_WORD ? CYC_SKIP2 : CYC_SKIP1; // see RL2 see RL10
            BTCC_OP_CALL_L:
                next_cycles = CYC_CALL; // see RL5
            default:
                next_cycles = CYC_ONE;
        endcase
    end

    // Multi-cycle operations hold READY low so the decoder cannot issue over them
    always_ff @(posedge CORE_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            state    <= ST_IDLE;
            busy_cnt <= 3'h0;
            READY    <= 1'b1;
        end
        else
        begin
            case (state)
                ST_IDLE:
                    if (take && (next_cycles != CYC_ONE))
                    begin
                        state    <= ST_BUSY;
                        busy_cnt <= next_cycles - 3'h2;
                        READY    <= 1'b0;
                    end
                ST_BUSY:
                    if (busy_cnt == 3'h0)
                    begin
                        state <= ST_DONE;
                        READY <= 1'b1;
                    end
                    else
                        busy_cnt <= busy_cnt - 3'h1;
                ST_DONE:
                    state <= ST_IDLE;
                default:
                begin
                    state <= ST_IDLE;
                    READY <= 1'b1;
                end
            endcase
            if (state == ST_DONE && take && (next_cycles != CYC_ONE))
            begin
                state    <= ST_BUSY;
                busy_cnt <= next_cycles - 3'h2;
                READY    <= 1'b0;
            end
        end
    end

    // Flags: only the bits an operation names are written, the rest hold
    always_ff @(posedge CORE_CLK or negedge NRST)
    begin
        if (!NRST)
            STATUS_FLAGS <= FLAGS_RESET;
        else if (take)
        begin
            if (OPCODE == BTCC_OP_TSET_C)
                STATUS_FLAGS[FLG_C] <= bit_val;  // see RL3
            else if (OPCODE == BTCC_OP_TSET_Z)
                STATUS_FLAGS[FLG_Z] <= ~bit_val; // see RL4
            else if (is_cmp(OPCODE))
                STATUS_FLAGS <= alu.flags;       // see RL6 see RL7 see RL8 see RL9
        end
    end

    always_ff @(posedge CORE_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            WB_VALID <= 1'b0;
            WB_DATA  <= ZERO_WORD;
        end
        else
        begin
            // Compares never write back, so the operand is left as it was
            WB_VALID <= take && ((OPCODE == BTCC_OP_TSET_C) || (OPCODE == BTCC_OP_TSET_Z));
            WB_DATA  <= OPERAND_A | (16'h0001 << BIT_SEL); // see RL3 see RL4
        end
    end

    always_ff @(posedge CORE_CLK or negedge NRST)
    begin
        if (!NRST)
            SKIP_NEXT <= 1'b0;
        else
            SKIP_NEXT <= take && (((OPCODE == BTCC_OP_SKIP_CLR) && !bit_val)
                               || ((OPCODE == BTCC_OP_SKIP_SET) && bit_val)); // see RL1 see RL2
    end

    always_ff @(posedge CORE_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            BRANCH_VALID       <= 1'b0;
            BRANCH_TARGET      <= 24'h000000;
            PUSH_VALID         <= 1'b0;
            PUSH_DATA          <= 24'h000000;
            STACK_FRAME_ACTIVE <= 1'b0;
        end
        else
        begin
            BRANCH_VALID <= take && (OPCODE == BTCC_OP_CALL_L);
            PUSH_VALID   <= take && (OPCODE == BTCC_OP_CALL_L);
            if (take && (OPCODE == BTCC_OP_CALL_L))
            begin
                BRANCH_TARGET      <= {OPERAND_B[7:0], OPERAND_A} & 24'hfffffe; // see RL5
                PUSH_DATA          <= RETURN_PC;
                STACK_FRAME_ACTIVE <= 1'b0; // see RL5
            end
        end
    end

    sequence call_taken_s;
        ISSUE && READY && (OPCODE == BTCC_OP_CALL_L);
    endsequence

    sequence busy_three_s;
        !READY [*3];
    endsequence

    call_busy_a: assert property (@(posedge CORE_CLK) disable iff (!NRST) // see RL5
        call_taken_s |=> busy_three_s ##1 READY)
        else $error("Call did not occupy four cycles");

    skip_clr_a: assert property (@(posedge CORE_CLK) disable iff (!NRST) // see RL1
        (take && OPCODE == BTCC_OP_SKIP_CLR && !bit_val) |=> SKIP_NEXT)
        else $error("Clear-bit skip missed");

    skip_set_a: assert property (@(posedge CORE_CLK) disable iff (!NRST) // see RL2
        (take && OPCODE == BTCC_OP_SKIP_SET) |=> (SKIP_NEXT == $past(bit_val)))
        else $error("Set-bit skip wrong");

    skip_flags_a: assert property (@(posedge CORE_CLK) disable iff (!NRST) // see RL1 see RL2
        (take && (OPCODE == BTCC_OP_SKIP_CLR || OPCODE == BTCC_OP_SKIP_SET))
        |=> $stable(STATUS_FLAGS))
        else $error("Skip changed flags");

    tset_carry_a: assert property (@(posedge CORE_CLK) disable iff (!NRST) // see RL3
        (take && OPCODE == BTCC_OP_TSET_C) |=> (STATUS_FLAGS[FLG_C] == $past(bit_val))
        && WB_VALID && READY)
        else $error("Test-set carry wrong");

    tset_zero_a: assert property (@(posedge CORE_CLK) disable iff (!NRST) // see RL4
        (take && OPCODE == BTCC_OP_TSET_Z) |=> (STATUS_FLAGS[FLG_Z] == !$past(bit_val))
        && $stable(STATUS_FLAGS[FLG_C]))
        else $error("Test-set zero wrong");

    cmp_lit_a: assert property (@(posedge CORE_CLK) disable iff (!NRST) // see RL6
        (take && OPCODE == BTCC_OP_CMP_LIT && OPERAND_A == {8'h00, LITERAL})
        |=> STATUS_FLAGS[FLG_Z] && STATUS_FLAGS[FLG_C] && READY)
        else $error("Literal compare flags wrong");

    cmp_reg_a: assert property (@(posedge CORE_CLK) disable iff (!NRST) // see RL7
        (take && OPCODE == BTCC_OP_CMP_REG && OPERAND_A < OPERAND_B)
        |=> !STATUS_FLAGS[FLG_C] && !STATUS_FLAGS[FLG_Z] && !WB_VALID)
        else $error("Register compare flags wrong");

    cmp_zero_a: assert property (@(posedge CORE_CLK) disable iff (!NRST) // see RL8 see RL9
        (take && OPCODE == BTCC_OP_CMP_ZERO)
        |=> (STATUS_FLAGS[FLG_Z] == ($past(OPERAND_A) == ZERO_WORD))
        && STATUS_FLAGS[FLG_C] && !WB_VALID)
        else $error("Zero compare flags wrong");

    skip_two_word_a: assert property (@(posedge CORE_CLK) disable iff (!NRST) // see RL10
        (take && OPCODE == BTCC_OP_SKIP_SET && bit_val && NEXT_TWO_WORD)
        |=> !READY ##1 !READY ##1 READY)
        else $error("Two-word skip not three cycles");
endmodule

// ===== logic/btcc_pkg.sv
/*
 Constants and types for the bit-test, call and compare execution block.
 Assumes a 16-bit datapath and a decoder upstream that presents one operation per issue.
*/
package btcc_pkg;
    localparam int          DATA_W       = 16;
    localparam int          ADDR_W       = 24;
    localparam int          BIT_W        = 4;
    localparam int          LIT_W        = 8;
    localparam logic [2:0]  CYC_ONE      = 3'h1;
    localparam logic [2:0]  CYC_SKIP1    = 3'h2;
    localparam logic [2:0]  CYC_SKIP2    = 3'h3;
    localparam logic [2:0]  CYC_CALL     = 3'h4;
    localparam logic [15:0] ZERO_WORD    = 16'h0000;
    localparam logic [4:0]  FLAGS_RESET  = 5'h00;
    localparam int          FLG_C        = 0;
    localparam int          FLG_Z        = 1;
    localparam int          FLG_OV       = 2;
    localparam int          FLG_N        = 3;
    localparam int          FLG_DC       = 4;

    typedef enum logic [3:0]
    {
        BTCC_OP_SKIP_CLR  = 4'h0,
        BTCC_OP_SKIP_SET  = 4'h1,
        BTCC_OP_TSET_C    = 4'h2,
        BTCC_OP_TSET_Z    = 4'h3,
        BTCC_OP_CALL_L    = 4'h4,
        BTCC_OP_CMP_LIT   = 4'h5,
        BTCC_OP_CMP_REG   = 4'h6,
        BTCC_OP_CMP_ZERO  = 4'h7
    } btcc_op_t;
endpackage

// ===== logic/btcc_alu_if.sv
/*
 Interface carrying operands to the compare unit and its flag result back.
 Assumes both ends run on the same core clock.
*/
`timescale 1ns/1ps
interface btcc_alu_if;
    import btcc_pkg::*;
    logic [DATA_W-1:0] minuend;
    logic [DATA_W-1:0] subtrahend;
    logic [4:0]        flags;

    modport core
    (
        output minuend,
        output subtrahend,
        input  flags
    );
    modport alu
    (
        input  minuend,
        input  subtrahend,
        output flags
    );
endinterface

// ===== logic/btcc_compare.sv
/*
 Compare unit: subtracts without storing and produces C, DC, N, OV, Z.
 Assumes purely combinational use; the caller registers the flags.
*/
`timescale 1ns/1ps
module btcc_compare
    import btcc_pkg::*;
(
    btcc_alu_if.alu bus
);
    logic [DATA_W:0] diff;
    logic [4:0]      low_diff;

    always_comb
    begin
        diff     = {1'b0, bus.minuend} - {1'b0, bus.subtrahend};
        low_diff = {1'b0, bus.minuend[3:0]} - {1'b0, bus.subtrahend[3:0]};
    end

    // Carry is the inverted borrow, as with any subtract-style compare
    always_comb
    begin
        bus.flags         = '0;
        bus.flags[FLG_C]  = ~diff[DATA_W];
        bus.flags[FLG_DC] = ~low_diff[4];
        bus.flags[FLG_N]  = diff[DATA_W-1];
        bus.flags[FLG_Z]  = (diff[DATA_W-1:0] == ZERO_WORD);
        bus.flags[FLG_OV] = (bus.minuend[DATA_W-1] != bus.subtrahend[DATA_W-1])
                          && (diff[DATA_W-1] != bus.minuend[DATA_W-1]);
    end
endmodule

// ===== tb/tb.sv
/*
 Self-checking bench for the bit-test, call and compare execution stage.
 Assumes btcc_pkg and btcc_exec are compiled first; single 40 MHz clock.
*/
`timescale 1ns/1ps
module tb;
    import btcc_pkg::*;
    logic        core_clk;
    logic        nrst;
    logic        issue;
    btcc_op_t    opcode;
    logic [15:0] operand_a;
    logic [15:0] operand_b;
    logic [3:0]  bit_sel;
    logic [7:0]  literal;
    logic        next_two_word;
    logic [23:0] return_pc;
    logic        ready;
    logic [4:0]  status_flags;
    logic        stack_frame_active;
    logic        skip_next;
    logic        wb_valid;
    logic [15:0] wb_data;
    logic        branch_valid;
    logic [23:0] branch_target;
    logic        push_valid;
    logic [23:0] push_data;
    int          fail_count;
    int          checks;
    int          cycles;
    int          n;
    logic [4:0]  ef;
    btcc_op_t    cop [8] = '{BTCC_OP_CMP_REG, BTCC_OP_CMP_REG, BTCC_OP_CMP_REG, BTCC_OP_CMP_REG,
                             BTCC_OP_CMP_LIT, BTCC_OP_CMP_LIT, BTCC_OP_CMP_ZERO, BTCC_OP_CMP_ZERO};
    logic [15:0] ca [8] = '{16'h8000, 16'h0010, 16'h1234, 16'h0001,
                            16'h00ff, 16'h0100, 16'h8000, 16'h0000};
    logic [15:0] cb [8] = '{16'h0001, 16'h0001, 16'h1234, 16'h0002,
                            16'hffff, 16'hffff, 16'hffff, 16'hffff};
    logic [7:0]  cl [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h01, 8'h00, 8'h00};

    btcc_exec btcc_exec_i
    (
        .CORE_CLK           (core_clk),
        .NRST               (nrst),
        .ISSUE              (issue),
        .OPCODE             (opcode),
        .OPERAND_A          (operand_a),
        .OPERAND_B          (operand_b),
        .BIT_SEL            (bit_sel),
        .LITERAL            (literal),
        .NEXT_TWO_WORD      (next_two_word),
        .RETURN_PC          (return_pc),
        .READY              (ready),
        .STATUS_FLAGS       (status_flags),
        .STACK_FRAME_ACTIVE (stack_frame_active),
        .SKIP_NEXT          (skip_next),
        .WB_VALID           (wb_valid),
        .WB_DATA            (wb_data),
        .BRANCH_VALID       (branch_valid),
        .BRANCH_TARGET      (branch_target),
        .PUSH_VALID         (push_valid),
        .PUSH_DATA          (push_data)
    );

    always #12.5 core_clk = ~core_clk;

    // Ceiling far above the roughly 60 cycles the scenarios need
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            fail_count++;
            close_out();
        end
    end

    task automatic close_out();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk_bit(string what, logic exp, logic got);
        checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("mismatch %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic chk_vec(string what, logic [23:0] exp, logic [23:0] got);
        checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Carry is not-borrow, digit carry is not-borrow out of bit 3
    function automatic logic [4:0] exp_sub(logic [15:0] a, logic [15:0] b);
        logic [15:0] r;
        logic [4:0]  f;
        r = a - b;
        f[FLG_C] = a >= b;
        f[FLG_DC] = a[3:0] >= b[3:0];
        f[FLG_N] = r[15];
        f[FLG_OV] = (a[15] != b[15]) && (r[15] != a[15]);
        f[FLG_Z] = r == 16'h0000;
        return f;
    endfunction

    // Hold keeps the request up so the next op is taken on the very next edge
    task automatic do_op(btcc_op_t op, logic [15:0] a, logic [15:0] b, logic [3:0] bs,
                         logic [7:0] lit, logic two, logic hold);
        if (issue !== 1'b1)
            issue = 1'b1;
        opcode = op;
        operand_a = a;
        operand_b = b;
        bit_sel = bs;
        literal = lit;
        next_two_word = two;
        @(posedge core_clk);
        #2;
        if (!hold)
            issue = 1'b0;
    endtask

    task automatic wait_ready();
        n = 1;
        while (ready !== 1'b1 && n < 8)
        begin
            @(posedge core_clk);
            #2;
            n++;
        end
    endtask

    task automatic t_skip();
        btcc_op_t    ops [2] = '{BTCC_OP_SKIP_CLR, BTCC_OP_SKIP_SET};
        logic [3:0]  bs;
        logic [15:0] a;
        logic        sk;
        for (int k = 0; k < 8; k++)
        begin
            bs = {k[1], k[2], k[1], ~k[2]};
            a = k[1] ? (16'h0001 << bs) : ~(16'h0001 << bs);
            sk = k[0] ? k[1] : !k[1];
            // Request drops only when a skip makes the stage busy
            do_op(ops[k[0]], a, 16'h0000, bs, 8'h00, k[2], !sk);
            chk_bit("skip", sk, skip_next);
            chk_vec("skip flags", {19'h0, ef}, {19'h0, status_flags});
            wait_ready();
            chk_vec("skip cycles", sk ? (k[2] ? 24'h3 : 24'h2) : 24'h1, 24'(n));
        end
    endtask

    task automatic t_tset();
        logic [3:0] bs;
        logic       v;
        for (int k = 0; k < 4; k++)
        begin
            v = k[1];
            bs = v ? 4'he : 4'hf;
            do_op(k[0] ? BTCC_OP_TSET_Z : BTCC_OP_TSET_C, 16'h5a5a, 16'h0000, bs, 8'h00, 1'b0,
                  1'b1);
            if (k[0])
                ef[FLG_Z] = !v;
            else
                ef[FLG_C] = v;
            chk_vec("tset flags", {19'h0, ef}, {19'h0, status_flags});
            chk_bit("tset wb", 1'b1, wb_valid);
            chk_vec("tset data", 24'(16'h5a5a | (16'h1 << bs)), 24'(wb_data));
            wait_ready();
            chk_vec("tset cycles", 24'h1, 24'(n));
        end
    endtask

    task automatic t_call();
        // The first call leaves a second offer standing; it must be refused while busy
        for (int j = 0; j < 2; j++)
        begin
            do_op(BTCC_OP_CALL_L, 16'h3457, 16'h00ab, 4'h0, 8'h00, 1'b0, j == 0);
            chk_bit("branch", 1'b1, branch_valid);
            chk_vec("target", 24'hab3456, branch_target);
            chk_bit("push", 1'b1, push_valid);
            chk_vec("push data", return_pc, push_data);
            chk_bit("frame flag", 1'b0, stack_frame_active);
            wait_ready();
            chk_vec("call cycles", 24'h4, 24'(n));
            chk_bit("branch end", 1'b0, branch_valid);
        end
    endtask

    task automatic t_cmp();
        logic [15:0] sub;
        for (int i = 0; i < 8; i++)
        begin
            sub = cop[i] == BTCC_OP_CMP_REG ? cb[i] :
                  (cop[i] == BTCC_OP_CMP_LIT ? {8'h00, cl[i]} : ZERO_WORD);
            do_op(cop[i], ca[i], cb[i], 4'h0, cl[i], 1'b0, 1'b1);
            ef = exp_sub(ca[i], sub);
            chk_vec("cmp flags", {19'h0, ef}, {19'h0, status_flags});
            chk_bit("cmp wb", 1'b0, wb_valid);
            chk_bit("cmp ready", 1'b1, ready);
        end
    endtask

    initial
    begin
        core_clk = 1'b0;
        nrst = 1'b0;
        issue = 1'b0;
        opcode = BTCC_OP_SKIP_CLR;
        operand_a = 16'h0000;
        operand_b = 16'h0000;
        bit_sel = 4'h0;
        literal = 8'h00;
        next_two_word = 1'b0;
        return_pc = 24'h123456;
        fail_count = 0;
        checks = 0;
        cycles = 0;
        ef = FLAGS_RESET;
        repeat (10) @(posedge core_clk);
        chk_bit("reset ready", 1'b1, ready);
        chk_vec("reset flags", {19'h0, FLAGS_RESET}, {19'h0, status_flags});
        #2;
        nrst = 1'b1;
        t_skip();
        t_tset();
        t_call();
        t_cmp();
        t_skip();
        close_out();
    end
endmodule
